//--- shs_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the standby controller
// Assumes: 10 MHz system clock, one clock domain
// Notes: Definitions only
`ifndef SHS_REGS_SVH
`define SHS_REGS_SVH

// Register address of the settle-time select register
`define SHS_SETTLE_SEL_ADDR 16'hfff4
`define SHS_SEL_LSB 0
`define SHS_SEL_MSB 1
`define SHS_SEL_RESET 2'h0
// Settle waits as powers of two of oscillator cycles
`define SHS_SETTLE_EXP0 5'h0a
`define SHS_SETTLE_EXP1 5'h0c
`define SHS_SETTLE_EXP2 5'h0f
`define SHS_SETTLE_EXP3 5'h11
// Wake wait in slow oscillator cycles
`define SHS_WAKE_SLOW_CYCLES 4'h8
// Slow oscillator stop bit position in its mode register
`define SHS_SLOW_STOP_BIT 0
// Clock source codes
`define SHS_SRC_XTAL 2'h0
`define SHS_SRC_HRING 2'h1
`define SHS_SRC_EXT 2'h2

`endif

//--- shs_pkg.sv
// Purpose: Types for the standby controller
// Assumes: Constants live in shs_regs.svh
// Notes: Nothing is imported by users
package shs_pkg;

    // Standby sequencer states
    typedef enum logic [2:0] {
        SHS_RUN,
        SHS_HALT,
        SHS_STOP,
        SHS_OSC_START,
        SHS_WAKE_WAIT,
        SHS_SETTLE
    } shs_state_t;

endpackage : shs_pkg

//--- shs_settle_counter.sv
// Purpose: Oscillator settle counter selecting 2^10, 2^12, 2^15 or 2^17 cycles
// Assumes: Counts only while the oscillator reports it is running
// Notes: done_o pulses one cycle when the count completes
`timescale 1ns/100ps
`include "shs_regs.svh"

module shs_settle_counter (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic osc_running_i,
    input wire logic [1:0] select_i,
    output logic done_o
);

    logic [17:0] count;
    logic [17:0] limit;
    logic active;

    // Map the select code to the terminal count
    function automatic logic [17:0] settle_limit(input logic [1:0] sel);
        logic [4:0] e;
        e = `SHS_SETTLE_EXP0;
        unique case (sel)
            2'h0: e = `SHS_SETTLE_EXP0;
            2'h1: e = `SHS_SETTLE_EXP1;
            2'h2: e = `SHS_SETTLE_EXP2;
            2'h3: e = `SHS_SETTLE_EXP3;
        endcase
        settle_limit = 18'(18'h0_0001 << e) - 18'h0_0001;
    endfunction : settle_limit

    assign limit = settle_limit(select_i);

    // Count oscillator cycles; time before oscillation starts is skipped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= 18'h0_0000;
            active <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                count <= 18'h0_0000;
                active <= 1'b1;
            end else if (active && osc_running_i) begin
                if (count == limit) begin
                    active <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    count <= count + 18'h0_0001;
                end
            end
        end
    end

endmodule : shs_settle_counter

//--- shs_standby_ctrl.sv
// Purpose: HALT and STOP standby sequencer with settle-time select register
// Assumes: Wake inputs, slow oscillator tick and bus strobes are synchronous to clk_i
// Notes: Clock enables are registered and follow the next state
// Contract
// - Halt instruction gates core clock
// - System oscillator runs during HALT
// - Running slow oscillator stays on in HALT
// - Stop instruction shuts system oscillator off
// - Interrupt request ends STOP state
// - Eight slow cycles, then settle wait
// - Registers and memory kept in standby
// - Port latches and buffers held unchanged
// - Settle wait only after STOP, crystal
// - No settle wait for ring/external
// - Select code picks 2^10..2^17 cycles
// - Select register 8-bit, upper bits zero
// - Settle count starts at oscillation start
// - Slow stop bit needs option permission
// - Running slow oscillator kept during STOP
// - Slow-clocked watchdog stops in STOP
// - Unmasked request releases HALT state
// - Pending unmasked request exits standby immediately
`timescale 1ns/100ps
`include "shs_regs.svh"

module shs_standby_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic halt_instr_i,
    input wire logic stop_instr_i,
    input wire logic [7:0] int_request_flags_0_i,
    input wire logic [7:0] int_mask_flags_0_i,
    input wire logic [1:0] clk_source_i,
    input wire logic slow_osc_stoppable_i,
    input wire logic slow_osc_stop_bit_i,
    input wire logic wdt_on_slow_clk_i,
    input wire logic slow_tick_i,
    input wire logic sys_osc_running_i,
    input wire logic [15:0] bus_addr_i,
    input wire logic [7:0] bus_wdata_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    output logic [7:0] bus_rdata_o,
    output logic cpu_clk_en_o,
    output logic periph_clk_en_o,
    output logic sys_osc_en_o,
    output logic slow_osc_en_o,
    output logic wdt_stop_o,
    output logic hold_state_o,
    output logic standby_o
);

    shs_pkg::shs_state_t state;
    shs_pkg::shs_state_t next_state;
    logic [1:0] osc_settle_time_select;
    logic [3:0] wake_count;
    logic wake_req;
    logic osc_is_xtal;
    logic slow_run_req;
    logic settle_start;
    logic settle_done;
    logic sel_hit;

    // True in normal operation, the only state in which the core clock runs
    function automatic logic is_running(input shs_pkg::shs_state_t s);
        is_running = (s == shs_pkg::SHS_RUN);
    endfunction : is_running

    // True in the two standby states proper
    function automatic logic is_standby(input shs_pkg::shs_state_t s);
        is_standby = (s == shs_pkg::SHS_HALT) || (s == shs_pkg::SHS_STOP);
    endfunction : is_standby

    // True while the system oscillator must stay switched off
    function automatic logic is_osc_off(input shs_pkg::shs_state_t s);
        is_osc_off = (s == shs_pkg::SHS_STOP) || (s == shs_pkg::SHS_WAKE_WAIT);
    endfunction : is_osc_off

    // Wake when any source is requested and unmasked
    assign wake_req = |(int_request_flags_0_i & ~int_mask_flags_0_i);
    // Only a crystal or ceramic resonator needs a settle wait after restart
    assign osc_is_xtal = (clk_source_i == `SHS_SRC_XTAL);
    assign sel_hit = (bus_addr_i == `SHS_SETTLE_SEL_ADDR);

    // Settle-time select register; only the low two bits are stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_settle_time_select <= `SHS_SEL_RESET;
        end else if (bus_wr_i && sel_hit) begin
            osc_settle_time_select <= bus_wdata_i[`SHS_SEL_MSB:`SHS_SEL_LSB];
        end
    end

    // Read data; upper bits read as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_rdata_o <= 8'h00;
        end else if (bus_rd_i && sel_hit) begin
            bus_rdata_o <= {6'h00, osc_settle_time_select};
        end else begin
            bus_rdata_o <= 8'h00;
        end
    end

    // State transitions
    always_comb begin
        next_state = state;
        unique case (state)
            shs_pkg::SHS_RUN: begin
                if (stop_instr_i && !wake_req) begin
                    next_state = shs_pkg::SHS_STOP;
                end else if (halt_instr_i && !wake_req) begin
                    next_state = shs_pkg::SHS_HALT;
                end
            end
            shs_pkg::SHS_HALT: begin
                if (wake_req) begin
                    next_state = shs_pkg::SHS_RUN;
                end
            end
            shs_pkg::SHS_STOP: begin
                if (wake_req) begin
                    next_state = shs_pkg::SHS_WAKE_WAIT;
                end
            end
            // Eight slow ticks with everything held, then restart or resume
            shs_pkg::SHS_WAKE_WAIT: begin
                if (slow_tick_i && wake_count == `SHS_WAKE_SLOW_CYCLES - 4'h1) begin
                    if (osc_is_xtal) begin
                        next_state = shs_pkg::SHS_OSC_START;
                    end else begin
                        next_state = shs_pkg::SHS_RUN;
                    end
                end
            end
            // Oscillator enabled again; the gap before it oscillates is not counted
            shs_pkg::SHS_OSC_START: begin
                if (sys_osc_running_i) begin
                    next_state = shs_pkg::SHS_SETTLE;
                end
            end
            // Settle count running; resume when it completes
            shs_pkg::SHS_SETTLE: begin
                if (settle_done) begin
                    next_state = shs_pkg::SHS_RUN;
                end
            end
            // Unused codes fall back to normal operation
            default: begin
                next_state = shs_pkg::SHS_RUN;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= shs_pkg::SHS_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Count slow oscillator cycles after STOP release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_count <= 4'h0;
        end else if (state != shs_pkg::SHS_WAKE_WAIT) begin
            wake_count <= 4'h0;
        end else if (slow_tick_i) begin
            wake_count <= wake_count + 4'h1;
        end
    end

    // Start the settle count once the restarted oscillator is seen oscillating
    assign settle_start = (state == shs_pkg::SHS_OSC_START) && sys_osc_running_i;

    shs_settle_counter u_settle (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(settle_start),
        .osc_running_i(sys_osc_running_i),
        .select_i(osc_settle_time_select),
        .done_o(settle_done)
    );

    // Software stop request for the slow oscillator, honoured only if the option allows
    assign slow_run_req = !(slow_osc_stoppable_i && slow_osc_stop_bit_i);

    // Slow oscillator follows software in normal operation only; frozen in standby,
    // so a slow clock that ran on entry keeps running until the block is back in RUN
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slow_osc_en_o <= 1'b1;
        end else if (is_running(state)) begin
            slow_osc_en_o <= slow_run_req;
        end
    end

    // Core clock runs only in normal operation; it stays off through all wake waits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_clk_en_o <= 1'b1;
        end else begin
            cpu_clk_en_o <= is_running(next_state);
        end
    end

    // Peripherals keep their clock in HALT and lose it until STOP is fully left
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            periph_clk_en_o <= 1'b1;
        end else begin
            periph_clk_en_o <= is_running(next_state) ||
                               (next_state == shs_pkg::SHS_HALT);
        end
    end

    // System oscillator off in STOP and through the slow wake wait only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sys_osc_en_o <= 1'b1;
        end else begin
            sys_osc_en_o <= !is_osc_off(next_state);
        end
    end

    // Watchdog on the slow clock is stopped for the STOP period
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdt_stop_o <= 1'b0;
        end else begin
            wdt_stop_o <= wdt_on_slow_clk_i && (next_state == shs_pkg::SHS_STOP);
        end
    end

    // Core, registers, memory and port latches hold while not running
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_state_o <= 1'b0;
        end else begin
            hold_state_o <= !is_running(next_state);
        end
    end

    // Standby indication covers HALT and STOP, not the wake waits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            standby_o <= 1'b0;
        end else begin
            standby_o <= is_standby(next_state);
        end
    end

endmodule : shs_standby_ctrl

//--- shs_standby_ctrl_props.sv
// Purpose: Port checker for the standby controller
// Assumes: One clock, synchronous reset
// Notes: Bound after the module
`timescale 1ns/100ps
module shs_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic halt_instr_i,
    input wire logic stop_instr_i,
    input wire logic [7:0] int_request_flags_0_i,
    input wire logic [7:0] int_mask_flags_0_i,
    input wire logic slow_osc_stoppable_i,
    input wire logic wdt_on_slow_clk_i,
    input wire logic [15:0] bus_addr_i,
    input wire logic bus_rd_i,
    input wire logic [7:0] bus_rdata_o,
    input wire logic cpu_clk_en_o,
    input wire logic periph_clk_en_o,
    input wire logic sys_osc_en_o,
    input wire logic slow_osc_en_o,
    input wire logic wdt_stop_o,
    input wire logic standby_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic wake;
    logic run;
    logic go;
    // Wake request, running state and a request that may be taken
    assign wake = |(int_request_flags_0_i & ~int_mask_flags_0_i);
    assign run = cpu_clk_en_o & ~standby_o;
    assign go = run & ~wake;
    property p_halt; go && halt_instr_i && !stop_instr_i |=> !cpu_clk_en_o && sys_osc_en_o;
    endproperty
    a_halt: assert property (p_halt) else $error("halt entry wrong");
    property p_stop; go && stop_instr_i |=> !sys_osc_en_o && !periph_clk_en_o && standby_o;
    endproperty
    a_stop: assert property (p_stop) else $error("stop entry wrong");
    property p_imm; run && wake && (halt_instr_i || stop_instr_i) |=> run;
    endproperty
    a_imm: assert property (p_imm) else $error("pending wake ignored");
    property p_hexit; standby_o && sys_osc_en_o && wake |=> run;
    endproperty
    a_hexit: assert property (p_hexit) else $error("halt not released");
    property p_hold; standby_o && sys_osc_en_o && !wake |=> standby_o;
    endproperty
    a_hold: assert property (p_hold) else $error("masked request woke");
    property p_sexit; standby_o && !sys_osc_en_o && wake |=> !standby_o ##0 !cpu_clk_en_o[*8];
    endproperty
    a_sexit: assert property (p_sexit) else $error("stop exit wrong");
    property p_slow; standby_o && $past(standby_o) |-> $stable(slow_osc_en_o);
    endproperty
    a_slow: assert property (p_slow) else $error("slow osc changed");
    property p_opt; run && !slow_osc_stoppable_i |=> slow_osc_en_o;
    endproperty
    a_opt: assert property (p_opt) else $error("slow osc stopped");
    property p_wdt; standby_o && !sys_osc_en_o |-> wdt_stop_o == wdt_on_slow_clk_i;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog stop wrong");
    property p_rd; bus_rd_i |=> bus_rdata_o[7:2] == 6'h00;
    endproperty
    a_rd: assert property (p_rd) else $error("upper bits set");
endmodule : shs_props
bind shs_standby_ctrl shs_props u_props (.clk_i, .rst_i, .halt_instr_i, .stop_instr_i,
    .int_request_flags_0_i, .int_mask_flags_0_i, .slow_osc_stoppable_i, .wdt_on_slow_clk_i,
    .bus_addr_i, .bus_rd_i, .bus_rdata_o, .cpu_clk_en_o, .periph_clk_en_o, .sys_osc_en_o,
    .slow_osc_en_o, .wdt_stop_o, .standby_o);

//--- shs_osc_model.sv
// Purpose: Oscillator side of the standby controller
// Assumes: Slow clock is a quarter of the system clock
// Notes: Start-up gap of three cycles
`timescale 1ns/100ps
module shs_osc_model (
    input wire logic clk_i,
    input wire logic sys_osc_en_i,
    output logic slow_tick_o,
    output logic sys_osc_running_o
);
    logic [1:0] div = 2'h0;
    logic [1:0] start = 2'h0;
    // One tick every four system cycles
    always_ff @(posedge clk_i) begin
        div <= div + 2'h1;
        slow_tick_o <= (div == 2'h3);
    end
    // Oscillation shows only some cycles after enable
    always_ff @(posedge clk_i) begin
        start <= !sys_osc_en_i ? 2'h0 : (start == 2'h3) ? start : start + 2'h1;
    end
    assign sys_osc_running_o = (start == 2'h3);
endmodule : shs_osc_model

//--- tb_standby_halt_stop_control.sv
// Purpose: Self-checking bench of the standby controller
// Assumes: Crystal settle codes 0 to 2 only (up to 2^15 cycles) keep the run short
// Notes: Random flags and codes from a fixed seed
`timescale 1ns/100ps
module tb_standby_halt_stop_control;
    logic clk_i = 1'b0, rst_i = 1'b1, halt_instr_i = 1'b0, stop_instr_i = 1'b0;
    logic bus_wr_i = 1'b0, bus_rd_i = 1'b0, wdt_on_slow_clk_i = 1'b0, sl;
    logic slow_osc_stoppable_i = 1'b0, slow_osc_stop_bit_i = 1'b0;
    logic [7:0] int_request_flags_0_i = 8'h00, int_mask_flags_0_i = 8'hff, bus_wdata_i = 8'h00;
    logic [1:0] clk_source_i = 2'h0;
    logic [15:0] bus_addr_i = 16'h0000;
    logic slow_tick_i, sys_osc_running_i, cpu_clk_en_o, periph_clk_en_o, sys_osc_en_o;
    logic slow_osc_en_o, wdt_stop_o, hold_state_o, standby_o;
    logic [7:0] bus_rdata_o, st, v;
    int error_cnt = 0, n_checks = 0, k;
    shs_standby_ctrl DUT (.clk_i, .rst_i, .halt_instr_i, .stop_instr_i, .int_request_flags_0_i,
        .int_mask_flags_0_i, .clk_source_i, .slow_osc_stoppable_i, .slow_osc_stop_bit_i,
        .wdt_on_slow_clk_i, .slow_tick_i, .sys_osc_running_i, .bus_addr_i, .bus_wdata_i,
        .bus_wr_i, .bus_rd_i, .bus_rdata_o, .cpu_clk_en_o, .periph_clk_en_o, .sys_osc_en_o,
        .slow_osc_en_o, .wdt_stop_o, .hold_state_o, .standby_o);
    shs_osc_model OSC (.clk_i, .sys_osc_en_i(sys_osc_en_o), .slow_tick_o(slow_tick_i),
        .sys_osc_running_o(sys_osc_running_i));
    // Clock and packed status view
    always #50 clk_i = ~clk_i;
    assign st = {1'b0, hold_state_o, wdt_stop_o, slow_osc_en_o, standby_o, sys_osc_en_o,
        periph_clk_en_o, cpu_clk_en_o};
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus_addr_i <= a;
        bus_wdata_i <= d;
        bus_wr_i <= w;
        bus_rd_i <= ~w;
        @(posedge clk_i);
        bus_wr_i <= 1'b0;
        bus_rd_i <= 1'b0;
        #1;
    endtask : bus
    task automatic pulse(input logic h);
        @(posedge clk_i);
        halt_instr_i <= h;
        stop_instr_i <= ~h;
        @(posedge clk_i);
        halt_instr_i <= 1'b0;
        stop_instr_i <= 1'b0;
        #1;
    endtask : pulse
    // Cycles from request to resume: eight slow ticks plus settle on crystal
    function automatic int lo_cyc(input logic [1:0] s, input logic [1:0] c);
        return 24 + ((s == 2'h0) ?
            (1 << ((c == 2'h0) ? 10 : (c == 2'h1) ? 12 : (c == 2'h2) ? 15 : 17)) : 0);
    endfunction : lo_cyc
    task automatic stop_run(input logic [1:0] s, input logic [1:0] c);
        int n;
        logic w;
        n = 0;
        w = 1'($urandom);
        bus(1'b1, 16'hfff4, {6'($urandom), c});
        @(posedge clk_i);
        clk_source_i <= s;
        wdt_on_slow_clk_i <= w;
        pulse(1'b0);
        chk(st & 8'hef, {2'h1, w, 5'h08});
        @(posedge clk_i);
        int_request_flags_0_i <= 8'h80;
        int_mask_flags_0_i <= 8'h7f;
        while (cpu_clk_en_o !== 1'b1 && n < 40000) begin
            @(posedge clk_i);
            #1 n++;
        end
        chk(8'(n >= lo_cyc(s, c) && n <= lo_cyc(s, c) + 24), 8'h01);
        @(posedge clk_i);
        int_request_flags_0_i <= 8'h00;
        int_mask_flags_0_i <= 8'hff;
    endtask : stop_run
    task automatic give_verdict();
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    // Main sequence: registers, halt, pending wake, stop per source
    initial begin
        v = 8'($urandom(58));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, 16'hfff4, 8'h00);
        chk(bus_rdata_o, 8'h00);
        repeat (4) begin
            v = 8'($urandom);
            bus(1'b1, 16'hfff4, v);
            bus(1'b0, 16'hfff4, 8'h00);
            chk(bus_rdata_o, {6'h00, v[1:0]});
        end
        bus(1'b0, 16'hfff5, 8'h00);
        chk(bus_rdata_o, 8'h00);
        repeat (3) begin
            k = $urandom_range(7);
            @(posedge clk_i);
            slow_osc_stoppable_i <= 1'($urandom);
            slow_osc_stop_bit_i <= 1'($urandom);
            int_request_flags_0_i <= 8'($urandom) | (8'h01 << k);
            pulse(1'b1);
            sl = !(slow_osc_stoppable_i && slow_osc_stop_bit_i);
            chk(st, {3'h2, sl, 4'he});
            repeat (3) @(posedge clk_i);
            int_mask_flags_0_i <= ~(8'h01 << k);
            #1 chk(st, {3'h2, sl, 4'he});
            repeat (2) @(posedge clk_i);
            #1 chk(st, {3'h0, sl, 4'h7});
            pulse(1'b0);
            chk(st, {3'h0, sl, 4'h7});
            @(posedge clk_i);
            int_mask_flags_0_i <= 8'hff;
        end
        for (int i = 0; i < 5; i++) stop_run(i < 3 ? 2'h0 : 2'(i - 2), i < 3 ? 2'(i) : 2'h3);
        // Reset in the middle of STOP returns straight to normal operation
        pulse(1'b0);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        #1 chk(st, 8'h17);
        give_verdict();
    end
    // Watchdog on a hung run
    initial begin
        repeat (60000) @(posedge clk_i);
        error_cnt++;
        give_verdict();
    end
endmodule : tb_standby_halt_stop_control
